// ===== hdl/lic_pkg.sv
package lic_pkg;

   // ----------------------------------------------------------------
   // register map (printed offsets are not word aligned: indices)
   // ----------------------------------------------------------------
   localparam logic [7:0]  IDX_CTRL_ONE  = 8'h30;
   localparam logic [7:0]  IDX_CTRL_TWO  = 8'h31;
   localparam logic [7:0]  IDX_BUILD_OUT = 8'h34;
   localparam logic [7:0]  IDX_MODE      = 8'h40;
   localparam int          ADDR_W        = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE  = {2'b00, IDX_CTRL_ONE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO  = {2'b00, IDX_CTRL_TWO, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_BUILD_OUT = {2'b00, IDX_BUILD_OUT, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MODE      = {2'b00, IDX_MODE, 2'b00};

   localparam logic [7:0]  RST_CTRL_ONE  = 8'h00;
   localparam logic [7:0]  RST_CTRL_TWO  = 8'h00;
   localparam logic [7:0]  RST_BUILD_OUT = 8'h00;
   localparam logic [1:0]  RST_MODE      = 2'h0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_TX_POWER_DOWN_N   = 0;
   localparam int BIT_ATTEN_DISABLE     = 1;
   localparam int BIT_BUFFER_DEPTH_SEL  = 2;
   localparam int BIT_PATH_SELECT       = 3;
   localparam int BIT_EQ_GAIN_LIMIT     = 4;
   localparam int BIT_BUILD_OUT_LO      = 5;
   localparam int BIT_CUSTOM_DRIVER     = 0;
   localparam int BIT_SHORT_LIMIT_DIS   = 1;
   localparam int BIT_CC_FILTER_EN      = 2;
   localparam int BIT_CLOCK_SEL_LO      = 3;
   localparam int BIT_ALARM_IND_TX      = 4;
   localparam int BIT_VIOLATION_INSERT  = 5;
   localparam int BIT_SOFT_RESET        = 6;
   localparam int BIT_CLOCK_SEL_HI      = 7;
   localparam int BIT_AUTO_GAIN_SELECT  = 6;
   localparam logic [7:0] BUILD_OUT_WMASK = 8'h7f;

   localparam logic [2:0] BO_E1_75_NORMAL  = 3'h0;
   localparam logic [2:0] BO_E1_120_NORMAL = 3'h1;
   localparam logic [2:0] BO_E1_75_HRL     = 3'h4;
   localparam logic [2:0] BO_E1_120_HRL    = 3'h5;
   localparam logic [2:0] BO_T1_LAST       = 3'h4;
   localparam int         ATTEN_DEPTH_LONG  = 128;
   localparam int         ATTEN_DEPTH_SHORT = 32;

   typedef enum logic [1:0] {LIC_MODE_T1, LIC_MODE_E1, LIC_MODE_CC64K, LIC_MODE_6312K} lic_mode_t;
   typedef enum logic [1:0] {LIC_DRV_OFF, LIC_DRV_PUSH_PULL, LIC_DRV_OPEN_DRAIN} lic_drive_t;

   typedef struct packed {
      logic        tx_enable;
      lic_drive_t  drive;
      logic        square_wave;
      logic [5:0]  gain;
      logic        auto_gain;
      logic        short_limit_en;
      logic        send_all_ones;
      logic        violation_req;
   } lic_tx_ctrl_t;

   typedef struct packed {
      logic        atten_enable;
      logic        atten_in_tx_path;
      logic [7:0]  atten_depth;
      logic        eq_short_haul;
      logic        cc_filter_en;
      logic        pll_2m_to_1m5_en;
      logic        pll_12m8_to_2m_en;
      logic        line_reset;
      logic [2:0]  build_out;
      logic        build_out_valid;
      logic        hrl_selected;
   } lic_rx_ctrl_t;

endpackage

// ===== hdl/lic_regs.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------
// Notes on behaviour
// RQ1: power-down bit low disables and tri-states driver
// RQ2: attenuator on when disable bit zero; code turns it on in T1 and E1 modes only
// RQ3: depth select: 0 long buffer, 1 short
// RQ4: path select: 0 receive, 1 transmit
// RQ5: gain limit bit picks receive sensitivity
// RQ6: E1 build-out codes 000,001,100,101 valid
// RQ7: software clears termination bits for high return loss
// RQ8: T1 codes up to 100 valid, rest reserved
// RQ9: six-bit gain field sets fixed transmit amplitude
// RQ10: auto gain bit zero ignores gain field
// RQ11: software writes zero to unused top bit
// RQ12: custom driver: square wave or open drain
// RQ13: software keeps custom driver bit zero normally
// RQ14: limit disable bit, ignored in 6312k mode; code enables the limit in E1 mode only
// RQ15: composite clock filter only in 64k mode
// RQ16: software sets clock selects even if disabled
// RQ17: clock select low enables 2.048-to-1.544 pll
// RQ18: alarm bit zero sends all ones
// RQ19: rising violation bit inserts one violation
// RQ20: rising reset bit pulses line reset
// RQ21: clock select high enables 12.8-to-2.048 pll
// RQ22: fields hold value, reads return stored value
module lic_regs
(
   input  wire logic                              clk,
   input  wire logic                              rst,
   input  wire logic [lic_pkg::ADDR_W-1:0]        s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [31:0]                       s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   output logic [1:0]                             s_axi_bresp,
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   input  wire logic [lic_pkg::ADDR_W-1:0]        s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   output logic [31:0]                            s_axi_rdata,
   output logic [1:0]                             s_axi_rresp,
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready,
   input  wire logic                              violation_done,
   output lic_pkg::lic_tx_ctrl_t                  tx_ctrl,
   output lic_pkg::lic_rx_ctrl_t                  rx_ctrl,
   output logic                                   tx_line_pos_oe,
   output logic                                   tx_line_neg_oe
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0]            ctrl_one_r;
   logic [7:0]            ctrl_two_r;
   logic [7:0]            build_out_r;
   logic [1:0]            mode_r;
   logic [7:0]            ctrl_two_prev_r;
   logic                  violation_pend_r;
   logic                  line_reset_r;

   logic                  aw_held_r;
   logic [lic_pkg::ADDR_W-1:0] aw_addr_r;
   logic                  w_held_r;
   logic [31:0]           w_data_r;
   logic [3:0]            w_strb_r;
   logic                  bvalid_r;
   logic [1:0]            bresp_r;
   logic                  rvalid_r;
   logic [31:0]           rdata_r;
   logic [1:0]            rresp_r;
   lic_pkg::lic_tx_ctrl_t tx_ctrl_r;
   lic_pkg::lic_rx_ctrl_t rx_ctrl_r;
   logic                  pos_oe_r;
   logic                  neg_oe_r;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic addr_sel(input logic [lic_pkg::ADDR_W-1:0] a);
      return (a == lic_pkg::ADDR_CTRL_ONE) || (a == lic_pkg::ADDR_CTRL_TWO)
             || (a == lic_pkg::ADDR_BUILD_OUT) || (a == lic_pkg::ADDR_MODE);
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic en);
      return en ? nw : old;
   endfunction

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   wire logic        aw_take   = s_axi_awvalid & ~aw_held_r & ~bvalid_r;
   wire logic        w_take    = s_axi_wvalid & ~w_held_r & ~bvalid_r;
   wire logic [lic_pkg::ADDR_W-1:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
   wire logic [31:0] wr_data   = w_held_r ? w_data_r : s_axi_wdata;
   wire logic [3:0]  wr_strb   = w_held_r ? w_strb_r : s_axi_wstrb;
   wire logic        wr_go     = (aw_held_r | aw_take) & (w_held_r | w_take);
   wire logic        wr_hit    = addr_sel(wr_addr);
   wire logic        lane0     = wr_go & wr_strb[0];
   wire logic        wr_one    = lane0 & (wr_addr == lic_pkg::ADDR_CTRL_ONE);
   wire logic        wr_two    = lane0 & (wr_addr == lic_pkg::ADDR_CTRL_TWO);
   wire logic        wr_bo     = lane0 & (wr_addr == lic_pkg::ADDR_BUILD_OUT);
   wire logic        wr_mode   = lane0 & (wr_addr == lic_pkg::ADDR_MODE);

   // fields hold their value until rewritten
   wire logic [7:0]  ctrl_one_nxt  = merge(ctrl_one_r, wr_data[7:0], wr_one);                       // RQ22
   wire logic [7:0]  ctrl_two_nxt  = merge(ctrl_two_r, wr_data[7:0], wr_two);                       // RQ22
   // top bit is unused and kept at zero
   wire logic [7:0]  build_out_nxt = merge(build_out_r, wr_data[7:0] & lic_pkg::BUILD_OUT_WMASK, wr_bo); // RQ22
   wire logic [1:0]  mode_nxt      = wr_mode ? wr_data[1:0] : mode_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_held_r  <= 1'b0;
         w_data_r  <= 32'h0;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= lic_pkg::RESP_OKAY;
      end
      else
      begin
         aw_held_r <= wr_go ? 1'b0 : (aw_held_r | aw_take);
         w_held_r  <= wr_go ? 1'b0 : (w_held_r | w_take);
         if (aw_take)
            aw_addr_r <= s_axi_awaddr;
         if (w_take)
         begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? lic_pkg::RESP_OKAY : lic_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   wire logic        ar_take = s_axi_arvalid & ~rvalid_r;
   wire logic        rd_hit  = addr_sel(s_axi_araddr);
   wire logic [7:0]  rd_byte = (s_axi_araddr == lic_pkg::ADDR_CTRL_ONE)  ? ctrl_one_r  :
                               (s_axi_araddr == lic_pkg::ADDR_CTRL_TWO)  ? ctrl_two_r  :
                               (s_axi_araddr == lic_pkg::ADDR_BUILD_OUT) ? build_out_r :
                               (s_axi_araddr == lic_pkg::ADDR_MODE)      ? {6'h00, mode_r} : 8'h00;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= lic_pkg::RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_r <= 1'b1;
         rdata_r  <= {24'h000000, rd_byte};                                                        // RQ22
         rresp_r  <= rd_hit ? lic_pkg::RESP_OKAY : lic_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // control registers and edge events
   // ----------------------------------------------------------------
   wire logic viol_rise  = ctrl_two_r[lic_pkg::BIT_VIOLATION_INSERT] & ~ctrl_two_prev_r[lic_pkg::BIT_VIOLATION_INSERT];
   wire logic reset_rise = ctrl_two_r[lic_pkg::BIT_SOFT_RESET] & ~ctrl_two_prev_r[lic_pkg::BIT_SOFT_RESET];
   // a new request wins over the completion seen in the same cycle
   wire logic violation_pend_nxt = viol_rise | (violation_pend_r & ~violation_done);              // RQ19

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_one_r       <= lic_pkg::RST_CTRL_ONE;
         ctrl_two_r       <= lic_pkg::RST_CTRL_TWO;
         build_out_r      <= lic_pkg::RST_BUILD_OUT;
         mode_r           <= lic_pkg::RST_MODE;
         ctrl_two_prev_r  <= lic_pkg::RST_CTRL_TWO;
         violation_pend_r <= 1'b0;
         line_reset_r     <= 1'b0;
      end
      else
      begin
         ctrl_one_r       <= ctrl_one_nxt;
         ctrl_two_r       <= ctrl_two_nxt;
         build_out_r      <= build_out_nxt;
         mode_r           <= mode_nxt;
         ctrl_two_prev_r  <= ctrl_two_r;
         violation_pend_r <= violation_pend_nxt;
         line_reset_r     <= reset_rise;                                                            // RQ20
      end
   end

   // ----------------------------------------------------------------
   // decoded line controls
   // ----------------------------------------------------------------
   wire lic_pkg::lic_mode_t mode = lic_pkg::lic_mode_t'(mode_r);
   wire logic       is_t1     = (mode == lic_pkg::LIC_MODE_T1);
   wire logic       is_e1     = (mode == lic_pkg::LIC_MODE_E1);
   wire logic [2:0] bo_code   = ctrl_one_r[lic_pkg::BIT_BUILD_OUT_LO +: 3];
   wire logic       tx_on     = ctrl_one_r[lic_pkg::BIT_TX_POWER_DOWN_N];                          // RQ1
   wire logic       custom    = ctrl_two_r[lic_pkg::BIT_CUSTOM_DRIVER];
   wire logic       bo_zero   = (bo_code == 3'h0);
   wire logic       e1_bo_ok  = (bo_code == lic_pkg::BO_E1_75_NORMAL) | (bo_code == lic_pkg::BO_E1_120_NORMAL)
                                | (bo_code == lic_pkg::BO_E1_75_HRL) | (bo_code == lic_pkg::BO_E1_120_HRL); // RQ6
   wire logic       t1_bo_ok  = (bo_code <= lic_pkg::BO_T1_LAST);                                   // RQ8
   wire logic       hrl       = is_e1 & ((bo_code == lic_pkg::BO_E1_75_HRL) | (bo_code == lic_pkg::BO_E1_120_HRL)); // RQ7
   wire logic       auto_gain = ~build_out_r[lic_pkg::BIT_AUTO_GAIN_SELECT];                        // RQ10

   wire lic_pkg::lic_drive_t drive_nxt = ~tx_on ? lic_pkg::LIC_DRV_OFF :                           // RQ1
                                         (custom & ~bo_zero) ? lic_pkg::LIC_DRV_OPEN_DRAIN :        // RQ12
                                         lic_pkg::LIC_DRV_PUSH_PULL;

   lic_pkg::lic_tx_ctrl_t tx_nxt;
   lic_pkg::lic_rx_ctrl_t rx_nxt;

   always_comb
   begin
      tx_nxt.tx_enable      = tx_on;                                                                // RQ1
      tx_nxt.drive          = drive_nxt;
      tx_nxt.square_wave    = tx_on & custom & bo_zero;                                             // RQ12
      tx_nxt.auto_gain      = auto_gain;                                                            // RQ10
      tx_nxt.gain           = auto_gain ? 6'h00 : build_out_r[5:0];                                 // RQ9
      tx_nxt.short_limit_en = is_e1 & ~ctrl_two_r[lic_pkg::BIT_SHORT_LIMIT_DIS];                    // RQ14
      tx_nxt.send_all_ones  = ~ctrl_two_r[lic_pkg::BIT_ALARM_IND_TX];                               // RQ18
      tx_nxt.violation_req  = violation_pend_r;                                                     // RQ19
      rx_nxt.atten_enable   = (is_t1 | is_e1) & ~ctrl_one_r[lic_pkg::BIT_ATTEN_DISABLE];            // RQ2
      rx_nxt.atten_in_tx_path = ctrl_one_r[lic_pkg::BIT_PATH_SELECT];                               // RQ4
      rx_nxt.atten_depth    = ctrl_one_r[lic_pkg::BIT_BUFFER_DEPTH_SEL] ?
                              8'(lic_pkg::ATTEN_DEPTH_SHORT) : 8'(lic_pkg::ATTEN_DEPTH_LONG);       // RQ3
      rx_nxt.eq_short_haul  = ctrl_one_r[lic_pkg::BIT_EQ_GAIN_LIMIT];                               // RQ5
      rx_nxt.cc_filter_en   = (mode == lic_pkg::LIC_MODE_CC64K)
                              & ctrl_two_r[lic_pkg::BIT_CC_FILTER_EN];                              // RQ15
      rx_nxt.pll_2m_to_1m5_en  = ctrl_two_r[lic_pkg::BIT_CLOCK_SEL_LO];                             // RQ17
      rx_nxt.pll_12m8_to_2m_en = ctrl_two_r[lic_pkg::BIT_CLOCK_SEL_HI];                             // RQ21
      rx_nxt.line_reset     = line_reset_r;                                                         // RQ20
      rx_nxt.build_out      = bo_code;
      rx_nxt.build_out_valid = is_e1 ? e1_bo_ok : (is_t1 ? t1_bo_ok : 1'b1);                        // RQ6 RQ8
      rx_nxt.hrl_selected   = hrl;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_ctrl_r <= '0;
         rx_ctrl_r <= '0;
         pos_oe_r  <= 1'b0;
         neg_oe_r  <= 1'b0;
      end
      else
      begin
         tx_ctrl_r <= tx_nxt;
         rx_ctrl_r <= rx_nxt;
         pos_oe_r  <= tx_on;                                                                        // RQ1
         neg_oe_r  <= tx_on;                                                                        // RQ1
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign s_axi_awready  = aw_take;
   assign s_axi_wready   = w_take;
   assign s_axi_bvalid   = bvalid_r;
   assign s_axi_bresp    = bresp_r;
   assign s_axi_arready  = ar_take;
   assign s_axi_rvalid   = rvalid_r;
   assign s_axi_rdata    = rdata_r;
   assign s_axi_rresp    = rresp_r;
   assign tx_ctrl        = tx_ctrl_r;
   assign rx_ctrl        = rx_ctrl_r;
   assign tx_line_pos_oe = pos_oe_r;
   assign tx_line_neg_oe = neg_oe_r;

endmodule

// ===== tb/lic_regs_monitor.sv
`timescale 1ns/100ps
module lic_regs_monitor
(
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic [1:0]            s_axi_bresp,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire lic_pkg::lic_tx_ctrl_t tx_ctrl,
   input wire lic_pkg::lic_rx_ctrl_t rx_ctrl,
   input wire logic                  tx_line_pos_oe,
   input wire logic                  tx_line_neg_oe
);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   a_oe_pair_match: assert property (tx_line_pos_oe == tx_line_neg_oe)
      else $error("transmit enables disagree");
   a_gain_when_agc: assert property (tx_ctrl.auto_gain |-> tx_ctrl.gain == 6'h00)
      else $error("gain passed while automatic gain on");
   a_square_code_zero: assert property (tx_ctrl.square_wave |-> rx_ctrl.build_out == 3'h0)
      else $error("square wave with nonzero build-out");
   // first edge after release still sees the cleared outputs
   a_depth_two_values: assert property (!$past(rst) |-> rx_ctrl.atten_depth inside {8'h80, 8'h20})
      else $error("attenuator depth not 128 or 32");
   a_reset_one_pulse: assert property (rx_ctrl.line_reset |=> !rx_ctrl.line_reset)
      else $error("line reset longer than one cycle");
   a_hrl_codes_only: assert property (rx_ctrl.hrl_selected |-> rx_ctrl.build_out[2] && !rx_ctrl.build_out[1])
      else $error("high return loss on wrong code");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_write_answered: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write not answered next cycle");
   a_read_answered: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 s_axi_rdata[31:8] == 24'h0)
      else $error("read not answered or upper bits set");
endmodule

bind lic_regs lic_regs_monitor lic_regs_monitor_i (.*);

// ===== tb/test_lic_regs.sv
`timescale 1ns/100ps
module test_lic_regs;
   typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] q; logic [1:0] r;} lic_row_t;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic [11:0]           s_axi_awaddr = 12'h000;
   logic [11:0]           s_axi_araddr = 12'h000;
   logic [31:0]           s_axi_wdata = 32'h0;
   logic [3:0]            s_axi_wstrb = 4'hf;
   logic                  s_axi_awvalid = 1'b0;
   logic                  s_axi_wvalid = 1'b0;
   logic                  s_axi_bready = 1'b0;
   logic                  s_axi_arvalid = 1'b0;
   logic                  s_axi_rready = 1'b0;
   logic                  violation_done = 1'b0;
   logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]            s_axi_bresp, s_axi_rresp, rsp_v;
   logic [31:0]           s_axi_rdata, rd_v;
   logic                  tx_line_pos_oe, tx_line_neg_oe;
   lic_pkg::lic_tx_ctrl_t tx_ctrl;
   lic_pkg::lic_rx_ctrl_t rx_ctrl;
   int                    err_total = 0;
   int                    check_count = 0;
   int                    cycles = 0;
   int                    pulses = 0;
   int                    slow = 0;
   lic_row_t              rows [5];

   lic_regs lic_regs_i (.*);

   always #5 clk = ~clk;

   // ----------------------------------------------------------------
   // watchdog and line reset pulse counter
   // ----------------------------------------------------------------
   always @(negedge clk)
   begin
      cycles++;
      if (rx_ctrl.line_reset === 1'b1) pulses++;
      if (cycles == 20000)
      begin
         $display("[FAIL] %0t run hung", $time);
         err_total++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // bus cycles; slow holds the response ready back to test stalls
   // ----------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic aw, w, b;
      int   n = 0;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= (slow == 0);
      // ready is read mid-cycle, where it already stands for the coming edge
      do
      begin
         @(negedge clk);
         aw    = s_axi_awready;
         w     = s_axi_wready;
         b     = s_axi_bvalid & s_axi_bready;
         n    += s_axi_bvalid;
         rsp_v = s_axi_bresp;
         @(posedge clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         s_axi_bready <= !b && n >= slow;
      end
      while (!b);
   endtask

   task automatic rd(input logic [11:0] a);
      logic ar, b;
      int   n = 0;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= (slow == 0);
      do
      begin
         @(negedge clk);
         ar    = s_axi_arready;
         b     = s_axi_rvalid & s_axi_rready;
         n    += s_axi_rvalid;
         rd_v  = s_axi_rdata;
         rsp_v = s_axi_rresp;
         @(posedge clk);
         if (ar) s_axi_arvalid <= 1'b0;
         s_axi_rready <= !b && n >= slow;
      end
      while (!b);
   endtask

   // outputs trail the register by a cycle, so look after two
   task automatic nap;
      repeat (2) @(negedge clk);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial
   begin
      rows[0] = '{lic_pkg::ADDR_CTRL_ONE, 8'hff, 8'hff, lic_pkg::RESP_OKAY};
      rows[1] = '{lic_pkg::ADDR_CTRL_TWO, 8'h8f, 8'h8f, lic_pkg::RESP_OKAY};
      rows[2] = '{lic_pkg::ADDR_BUILD_OUT, 8'h7f, 8'h7f, lic_pkg::RESP_OKAY};
      rows[3] = '{12'h0c8, 8'h55, 8'h00, lic_pkg::RESP_SLVERR};
      rows[4] = '{lic_pkg::ADDR_CTRL_TWO, 8'h70, 8'h70, lic_pkg::RESP_OKAY};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         rd(rows[i].a);
         chk(rd_v, 32'h0);
      end
      chk(tx_line_pos_oe, 1'b0);
      $display("reset test done");
      foreach (rows[i])
      begin
         slow = i % 2;
         wr(rows[i].a, rows[i].d);
         chk(rsp_v, rows[i].r);
         rd(rows[i].a);
         chk(rsp_v, rows[i].r);
         chk(rd_v, {24'h0, rows[i].q});
      end
      slow = 0;
      s_axi_wstrb <= 4'he;
      wr(lic_pkg::ADDR_CTRL_ONE, 8'h00);
      s_axi_wstrb <= 4'hf;
      rd(lic_pkg::ADDR_CTRL_ONE);
      chk(rd_v, 32'hff);
      $display("table test done");
      wr(lic_pkg::ADDR_MODE, 8'h00);
      for (int v = 0; v < 2; v++)
      begin
         wr(lic_pkg::ADDR_CTRL_ONE, v ? 8'h1f : 8'h00);
         wr(lic_pkg::ADDR_BUILD_OUT, v ? 8'h6a : 8'h2a);
         nap();
         chk(tx_line_pos_oe, v[0]);
         chk(tx_line_neg_oe, v[0]);
         chk(tx_ctrl.tx_enable, v[0]);
         chk(tx_ctrl.drive, v ? lic_pkg::LIC_DRV_PUSH_PULL : lic_pkg::LIC_DRV_OFF);
         chk(rx_ctrl.atten_enable, !v[0]);
         chk(rx_ctrl.atten_depth, v ? 8'h20 : 8'h80);
         chk(rx_ctrl.atten_in_tx_path, v[0]);
         chk(rx_ctrl.eq_short_haul, v[0]);
         chk(tx_ctrl.gain, v ? 6'h2a : 6'h00);
         chk(tx_ctrl.auto_gain, !v[0]);
      end
      for (int m = 0; m < 2; m++)
         for (int c = 0; c < 8; c++)
         begin
            wr(lic_pkg::ADDR_MODE, m[7:0]);
            wr(lic_pkg::ADDR_CTRL_ONE, {c[2:0], 5'h01});
            nap();
            chk(rx_ctrl.build_out_valid, m ? (c inside {0, 1, 4, 5}) : (c < 5));
            chk(rx_ctrl.hrl_selected, m && (c == 4 || c == 5));
            chk(rx_ctrl.build_out, c[2:0]);
         end
      $display("field test done");
      wr(lic_pkg::ADDR_CTRL_ONE, 8'h01);
      wr(lic_pkg::ADDR_CTRL_TWO, 8'h9d);
      nap();
      chk(tx_ctrl.square_wave, 1'b1);
      chk(tx_ctrl.short_limit_en, 1'b1);
      chk(rx_ctrl.cc_filter_en, 1'b0);
      chk(rx_ctrl.pll_2m_to_1m5_en, 1'b1);
      chk(rx_ctrl.pll_12m8_to_2m_en, 1'b1);
      chk(tx_ctrl.send_all_ones, 1'b0);
      wr(lic_pkg::ADDR_CTRL_ONE, 8'h21);
      wr(lic_pkg::ADDR_CTRL_TWO, 8'h03);
      nap();
      chk(tx_ctrl.drive, lic_pkg::LIC_DRV_OPEN_DRAIN);
      chk(tx_ctrl.square_wave, 1'b0);
      chk(tx_ctrl.short_limit_en, 1'b0);
      chk(rx_ctrl.pll_2m_to_1m5_en, 1'b0);
      chk(rx_ctrl.pll_12m8_to_2m_en, 1'b0);
      chk(tx_ctrl.send_all_ones, 1'b1);
      wr(lic_pkg::ADDR_MODE, 8'h02);
      wr(lic_pkg::ADDR_CTRL_TWO, 8'h04);
      nap();
      chk(rx_ctrl.cc_filter_en, 1'b1);
      wr(lic_pkg::ADDR_MODE, 8'h03);
      wr(lic_pkg::ADDR_CTRL_TWO, 8'h00);
      nap();
      chk(tx_ctrl.short_limit_en, 1'b0);
      wr(lic_pkg::ADDR_MODE, 8'h01);
      wr(lic_pkg::ADDR_CTRL_TWO, 8'h20);
      nap();
      chk(tx_ctrl.violation_req, 1'b1);
      @(posedge clk);
      violation_done <= 1'b1;
      @(posedge clk);
      violation_done <= 1'b0;
      nap();
      chk(tx_ctrl.violation_req, 1'b0);
      // rewriting a set bit is no rising edge, so nothing new is queued
      wr(lic_pkg::ADDR_CTRL_TWO, 8'h20);
      nap();
      chk(tx_ctrl.violation_req, 1'b0);
      wr(lic_pkg::ADDR_CTRL_TWO, 8'h00);
      wr(lic_pkg::ADDR_CTRL_TWO, 8'h20);
      nap();
      chk(tx_ctrl.violation_req, 1'b1);
      pulses = 0;
      for (int k = 0; k < 2; k++)
      begin
         wr(lic_pkg::ADDR_CTRL_TWO, 8'h40);
         repeat (6) @(negedge clk);
         chk(pulses, 1);
      end
      $display("control two test done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      nap();
      chk(tx_line_pos_oe, 1'b0);
      rd(lic_pkg::ADDR_CTRL_TWO);
      chk(rd_v, 32'h0);
      $display("second reset test done");
      end_sim();
   end
endmodule
